// ==== src/lpw_pkg.sv ====
// Package for the low-power mode and wake-up controller.
// Assumes a single 10 MHz system clock domain with synchronous reset.
package lpw_pkg;
   // Register byte offsets
   localparam logic [7:0] MODE_CTRL_OFS   = 8'h00;
   localparam logic [7:0] MODE_CTRL2_OFS  = 8'h04;
   localparam logic [7:0] STATUS_OFS      = 8'h08;
   localparam logic [7:0] PAWAKE_OFS      = 8'h0C;
   localparam logic [7:0] INTCTL_OFS      = 8'h10;
   // Field positions
   localparam int IDLE_SEL_BIT   = 1;
   localparam int SYSKEEP_BIT    = 7;
   localparam int PDF_BIT        = 0;
   localparam int TOF_BIT        = 1;
   localparam int WDTEN_BIT      = 0;
   localparam int WDTOVF_BIT     = 1;
   localparam int STACKFULL_BIT  = 2;
   // Reset values
   localparam logic [7:0] MODE_CTRL_RST  = 8'h03;
   localparam logic [7:0] MODE_CTRL2_RST = 8'h00;
   localparam logic [7:0] PAWAKE_RST     = 8'h00;
   localparam logic [7:0] INTCTL_RST     = 8'h00;
   // Widths
   localparam int PA_W  = 8;
   localparam int IRQ_W = 8;
   localparam int WDT_W = 16;
   // Oscillator settle time after wake, in ns, and derived cycle count
   localparam int CLK_PERIOD_NS = 100;
   localparam int SETTLE_NS     = 1000;
   localparam int SETTLE_CYC    =
      (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ST_RUN     = 3'b000,
      ST_DEEP    = 3'b001,
      ST_WDSLEEP = 3'b010,
      ST_CLOCK_OFF_IDLE_STATE   = 3'b011,
      ST_CLOCK_ON_IDLE_STATE   = 3'b100,
      ST_SETTLE  = 3'b101
   } lpw_state_t;

   typedef enum logic [1:0] {
      RES_NEXT = 2'h0,
      RES_IRQ  = 2'h1,
      RES_WDT  = 2'h2
   } lpw_resume_t;

   typedef struct packed {
      logic sysClkEn;
      logic tbClkEn;
      logic wdtClkEn;
   } lpw_clk_t;
endpackage

// ==== src/lpw_ctrl.sv ====
// Low-power mode selection, clock gating and wake-up control.
// Assumes a CPU core issuing halt and watchdog-clear strobes and an
// AXI4-Lite master for register access; all inputs synchronous to clk.
`timescale 1ns/10ps
module lpw_ctrl
   import lpw_pkg::*;
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // CPU core
   input  wire logic             haltExec,
   input  wire logic             wdtClearExec,
   output logic                  cpuRun,
   output logic                  resumeValid,
   output lpw_resume_t           resumeKind,
   output logic                  pcSpReset,
   // Interrupt controller and port A
   input  wire logic [IRQ_W-1:0] irqFlag,
   input  wire logic [IRQ_W-1:0] irqEnable,
   input  wire logic [PA_W-1:0]  portAIn,
   // Clock gates
   output lpw_clk_t              clkGate,
   // AXI4-Lite slave
   input  wire logic [7:0]       s_axi_awaddr,
   input  wire logic             s_axi_awvalid,
   output logic                  s_axi_awready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   input  wire logic             s_axi_wvalid,
   output logic                  s_axi_wready,
   output logic [1:0]            s_axi_bresp,
   output logic                  s_axi_bvalid,
   input  wire logic             s_axi_bready,
   input  wire logic [7:0]       s_axi_araddr,
   input  wire logic             s_axi_arvalid,
   output logic                  s_axi_arready,
   output logic [31:0]           s_axi_rdata,
   output logic [1:0]            s_axi_rresp,
   output logic                  s_axi_rvalid,
   input  wire logic             s_axi_rready
);
   lpw_state_t       state_r;
   lpw_state_t       state_nxt;
   logic [7:0]       modeCtrl_r;
   logic [7:0]       modeCtrl2_r;
   logic [PA_W-1:0]  paWake_r;
   logic [7:0]       intCtl_r;
   logic             pdf_r;
   logic             tof_r;
   logic [WDT_W-1:0] wdtCnt_r;
   logic [PA_W-1:0]  portAPrev_r;
   logic [IRQ_W-1:0] irqArmed_r;
   logic [3:0]       settleCnt_r;
   logic             irqWake;
   logic             paWake;
   logic             wdtWake;
   logic             asleep;
   logic             wdtEn;
   logic             stackFull;
   logic [7:0]       awAddr_r;
   logic             awHeld_r;
   logic [31:0]      wData_r;
   logic [3:0]       wStrb_r;
   logic             wHeld_r;
   logic             doWrite;
   logic             wrHit;

   assign wdtEn     = intCtl_r[WDTEN_BIT];
   assign stackFull = intCtl_r[STACKFULL_BIT];
   assign asleep    = (state_r != ST_RUN) && (state_r != ST_SETTLE);
   assign wdtWake   = asleep && intCtl_r[WDTOVF_BIT] && wdtEn
                      && (&wdtCnt_r);
   assign paWake    = |(paWake_r & portAPrev_r & ~portAIn);
   assign irqWake   = |(irqFlag & irqArmed_r);

   // Power state machine
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         ST_RUN:
            if (haltExec)
            begin
               if (!modeCtrl_r[IDLE_SEL_BIT])
                  state_nxt = wdtEn ? ST_WDSLEEP
                                    : ST_DEEP;
               else if (modeCtrl2_r[SYSKEEP_BIT])
                  state_nxt = ST_CLOCK_ON_IDLE_STATE;
               else
                  state_nxt = ST_CLOCK_OFF_IDLE_STATE;
            end
         ST_DEEP, ST_WDSLEEP, ST_CLOCK_OFF_IDLE_STATE, ST_CLOCK_ON_IDLE_STATE:
            if (paWake || irqWake || wdtWake)
               state_nxt = ST_SETTLE;
         ST_SETTLE:
            if (settleCnt_r == 4'(SETTLE_CYC - 1))
               state_nxt = ST_RUN;
         default:
            state_nxt = ST_RUN;
      endcase
   end

   // External reset arrives as reset_n and resets everything except the AXI write holding registers awAddr_r, wData_r and wStrb_r
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         state_r <= ST_RUN;
      else
         state_r <= state_nxt;
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n || state_r != ST_SETTLE)
         settleCnt_r <= 4'h0;
      else
         settleCnt_r <= settleCnt_r + 4'h1;
   end

   // Resume reason latched on wake
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         resumeKind <= RES_NEXT;
      else if (asleep && state_nxt == ST_SETTLE)
      begin
         if (wdtWake)
            resumeKind <= RES_WDT;
         else if (irqWake && |(irqFlag & irqArmed_r & irqEnable)
                  && !stackFull)
            resumeKind <= RES_IRQ;
         else
            resumeKind <= RES_NEXT;
      end
   end

   assign resumeValid = (state_r == ST_SETTLE) && (state_nxt == ST_RUN);
   assign pcSpReset   = resumeValid && (resumeKind == RES_WDT);
   assign cpuRun      = (state_r == ST_RUN);

   // Clock gates from flops
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         clkGate <= '{sysClkEn: 1'b1, tbClkEn: 1'b1, wdtClkEn: 1'b1};
      else
      begin
         clkGate.sysClkEn <= (state_nxt == ST_RUN) || (state_nxt == ST_SETTLE)
                             || (state_nxt == ST_CLOCK_ON_IDLE_STATE);
         clkGate.tbClkEn  <= (state_nxt == ST_RUN) || (state_nxt == ST_SETTLE)
                             || (state_nxt == ST_CLOCK_OFF_IDLE_STATE)
                             || (state_nxt == ST_CLOCK_ON_IDLE_STATE);
         clkGate.wdtClkEn <= (state_nxt != ST_DEEP);
      end
   end

   // Interrupts pending at entry are disarmed for wake
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         irqArmed_r <= '0;
      else if (state_r == ST_RUN && haltExec)
         irqArmed_r <= ~irqFlag;
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         portAPrev_r <= '0;
      else
         portAPrev_r <= portAIn;
   end

   // Watchdog counter
   always_ff @(posedge clk)
   begin
      if (!reset_n || wdtClearExec || (state_r == ST_RUN && haltExec))
         wdtCnt_r <= '0;
      else if (state_r == ST_DEEP)
         wdtCnt_r <= '0;
      else if (wdtEn && clkGate.wdtClkEn)
         wdtCnt_r <= wdtCnt_r + 16'h0001;
   end

   // Status flags; set wins over clear
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         pdf_r <= 1'b0;
      else if (state_r == ST_RUN && haltExec)
         pdf_r <= 1'b1;
      else if (wdtClearExec)
         pdf_r <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         tof_r <= 1'b0;
      else if (wdtWake)
         tof_r <= 1'b1;
      else if (state_r == ST_RUN && haltExec)
         tof_r <= 1'b0;
   end

   // AXI4-Lite write path
   assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
   assign s_axi_wready  = !wHeld_r && !s_axi_bvalid;
   assign doWrite       = awHeld_r && wHeld_r;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk)
   begin
      if (!reset_n || doWrite)
         awHeld_r <= 1'b0;
      else if (s_axi_awvalid && s_axi_awready)
         awHeld_r <= 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (s_axi_awvalid && s_axi_awready)
         awAddr_r <= s_axi_awaddr;
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n || doWrite)
         wHeld_r <= 1'b0;
      else if (s_axi_wvalid && s_axi_wready)
         wHeld_r <= 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (s_axi_wvalid && s_axi_wready)
      begin
         wData_r <= s_axi_wdata;
         wStrb_r <= s_axi_wstrb;
      end
   end

   always_comb
   begin
      unique case (awAddr_r)
         MODE_CTRL_OFS, MODE_CTRL2_OFS, PAWAKE_OFS, INTCTL_OFS,
         STATUS_OFS:
            wrHit = 1'b1;
         default:
            wrHit = 1'b0;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else if (doWrite)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // Registers hold through every low-power state
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         modeCtrl_r  <= MODE_CTRL_RST;
         modeCtrl2_r <= MODE_CTRL2_RST;
         paWake_r    <= PAWAKE_RST;
         intCtl_r    <= INTCTL_RST;
      end
      else if (doWrite && wStrb_r[0])
      begin
         if (awAddr_r == MODE_CTRL_OFS)
            modeCtrl_r <= wData_r[7:0];
         if (awAddr_r == MODE_CTRL2_OFS)
            modeCtrl2_r <= wData_r[7:0] & 8'h80;
         if (awAddr_r == PAWAKE_OFS)
            paWake_r <= wData_r[PA_W-1:0];
         if (awAddr_r == INTCTL_OFS)
            intCtl_r <= wData_r[7:0] & 8'h07;
      end
   end

   // AXI4-Lite read path
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RESP_OKAY;
         unique case (s_axi_araddr)
            MODE_CTRL_OFS:  s_axi_rdata <= {24'h0, modeCtrl_r};
            MODE_CTRL2_OFS: s_axi_rdata <= {24'h0, modeCtrl2_r};
            STATUS_OFS:     s_axi_rdata <= {24'h0, 5'h0, state_r == ST_RUN,
                                            tof_r, pdf_r};
            PAWAKE_OFS:     s_axi_rdata <= {24'h0, paWake_r};
            INTCTL_OFS:     s_axi_rdata <= {24'h0, intCtl_r};
            default:
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
endmodule // lpw_ctrl

// ==== dv/lpw_ctrl_sva.sv ====
// Assertions on the core-side ports and clock gates of the low-power controller.
// Bound onto lpw_ctrl; one clock, synchronous active-low reset.
`timescale 1ns/10ps
module lpw_ctrl_sva
   import lpw_pkg::*;
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        reset_n,
   // Core side and clock gates
   input wire logic        haltExec,
   input wire logic        cpuRun,
   input wire logic        resumeValid,
   input wire lpw_resume_t resumeKind,
   input wire logic        pcSpReset,
   input wire lpw_clk_t    clkGate
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic gatesOn;
   assign gatesOn = clkGate.sysClkEn & clkGate.tbClkEn;
   sequence s_halt; haltExec && cpuRun; endsequence
   sequence s_wdt; resumeValid && resumeKind == RES_WDT; endsequence
   property p_stop; s_halt |=> !cpuRun; endproperty
   property p_tbsys; !clkGate.tbClkEn |-> !clkGate.sysClkEn; endproperty
   property p_tbrun; !clkGate.tbClkEn |-> !cpuRun; endproperty
   property p_run; cpuRun |-> gatesOn; endproperty
   // Clocks must be up well before the core is let go
   property p_settle;
      resumeValid |-> $past(gatesOn, 8) && !$past(cpuRun, 8);
   endproperty
   property p_wake;
      $rose(cpuRun) |-> resumeValid || $past(resumeValid);
   endproperty
   property p_pcsp; pcSpReset |-> s_wdt; endproperty
   property p_wdt; s_wdt |-> pcSpReset; endproperty
   a_stop: assert property (p_stop)
      else $error("core ran on after halt");
   a_tbsys: assert property (p_tbsys)
      else $error("system clock on with time base off");
   a_tbrun: assert property (p_tbrun)
      else $error("core running with time base off");
   a_run: assert property (p_run)
      else $error("core running with clocks gated");
   a_settle: assert property (p_settle)
      else $error("resume without settle time");
   a_wake: assert property (p_wake)
      else $error("core restarted without a wake");
   a_pcsp: assert property (p_pcsp)
      else $error("stray pointer reset");
   a_wdt: assert property (p_wdt)
      else $error("watchdog resume without pointer reset");
endmodule // lpw_ctrl_sva

bind lpw_ctrl lpw_ctrl_sva u_sva (.clk, .reset_n, .haltExec, .cpuRun,
   .resumeValid, .resumeKind, .pcSpReset, .clkGate);

// ==== dv/lpw_cpu_model.sv ====
// Core model: turns bench requests into halt and watchdog-clear strobes.
// Assumes the controller's cpuRun tells whether the core may execute.
`timescale 1ns/10ps
module lpw_cpu_model
   import lpw_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Requests
   input wire logic haltReq,
   input wire logic clrReq,
   // Controller side
   input wire logic cpuRun,
   output logic     haltExec,
   output logic     wdtClearExec
);
   // A stopped core executes nothing, so strobes only while running
   always_ff @(posedge clk)
      haltExec <= reset_n && haltReq && cpuRun && !haltExec;
   always_ff @(posedge clk)
      wdtClearExec <= reset_n && clrReq && cpuRun && !wdtClearExec;
endmodule // lpw_cpu_model

// ==== dv/test_low_power_mode_and_wakeup.sv ====
// Self-checking bench for the low-power mode and wake-up controller.
// Assumes lpw_ctrl with the bound checker and the core model beside it.
`timescale 1ns/10ps
module test_low_power_mode_and_wakeup
   import lpw_pkg::*;
;
   typedef struct packed {
      logic [7:0]  md;
      logic [7:0]  md2;
      logic [7:0]  ctl;
      logic        irq;
      logic        ien;
      logic [2:0]  gt;
      logic [2:0]  msk;
      lpw_resume_t knd;
   } lpw_row_t;
   lpw_row_t    rows [5] = '{
      '{8'h00, 8'h00, 8'h00, 1'h0, 1'h0, 3'h0, 3'h7, RES_NEXT},
      '{8'h00, 8'h00, 8'h01, 1'h0, 1'h0, 3'h1, 3'h7, RES_NEXT},
      '{8'h02, 8'h00, 8'h00, 1'h1, 1'h1, 3'h2, 3'h6, RES_IRQ},
      '{8'h02, 8'h80, 8'h00, 1'h1, 1'h0, 3'h6, 3'h6, RES_NEXT},
      '{8'h02, 8'h80, 8'h04, 1'h1, 1'h1, 3'h6, 3'h6, RES_NEXT}};
   logic        clk = 1'h0, reset_n = 1'h0, haltReq = 1'h0;
   logic        clrReq = 1'h0, s_axi_bready = 1'h0, s_axi_rready = 1'h0;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic        s_axi_arvalid = 1'h0;
   logic [7:0]  irqFlag = 8'h00, irqEnable = 8'h00, portAIn = 8'hFF;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic        haltExec, wdtClearExec, cpuRun, resumeValid, pcSpReset;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, pc;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_rdata;
   logic [7:0]  d;
   lpw_resume_t resumeKind, k;
   lpw_clk_t    clkGate;
   int          n, bad_count = 0, tests_run = 0;

   lpw_ctrl uut (.clk, .reset_n, .haltExec, .wdtClearExec, .cpuRun,
      .resumeValid, .resumeKind, .pcSpReset, .irqFlag, .irqEnable,
      .portAIn, .clkGate, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   lpw_cpu_model core (.clk, .reset_n, .haltReq, .clrReq, .cpuRun,
      .haltExec, .wdtClearExec);

   initial forever #50 clk = ~clk;

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic axw(input logic [7:0] a, input logic [7:0] v);
      logic ad, dd;
      ad = 1'h0;
      dd = 1'h0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, v};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do
      begin
         @(posedge clk);
         ad |= s_axi_awready;
         dd |= s_axi_wready;
         if (ad) s_axi_awvalid <= 1'h0;
         if (dd) s_axi_wvalid <= 1'h0;
      end while (!(ad && dd));
      do @(posedge clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      r = s_axi_bresp;
   endtask

   task automatic axr(input logic [7:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      while (!s_axi_rvalid) @(posedge clk);
      s_axi_rready <= 1'h0;
      d = s_axi_rdata[7:0];
      r = s_axi_rresp;
   endtask

   // Halt when h is set, watchdog clear otherwise
   task automatic req(input logic h);
      @(posedge clk);
      if (h) haltReq <= 1'h1;
      else clrReq <= 1'h1;
      @(posedge clk);
      haltReq <= 1'h0;
      clrReq <= 1'h0;
      repeat (3) @(posedge clk);
   endtask

   task automatic pin(input logic [7:0] v);
      @(posedge clk);
      portAIn <= v;
      repeat (2) @(posedge clk);
      portAIn <= 8'hFF;
   endtask

   task automatic waitRes(input int lim);
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end while (!resumeValid && n < lim);
      k = resumeKind;
      pc = pcSpReset;
   endtask

   task automatic end_sim;
      $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial
   begin
      #10000000;
      bad_count++;
      end_sim();
   end

   initial
   begin
      repeat (8) @(posedge clk);
      reset_n <= 1'h1;
      axw(PAWAKE_OFS, 8'h01);
      foreach (rows[i])
      begin
         axw(MODE_CTRL_OFS, rows[i].md);
         axw(MODE_CTRL2_OFS, rows[i].md2);
         axw(INTCTL_OFS, rows[i].ctl);
         irqEnable <= {7'h00, rows[i].ien};
         req(1'h1);
         chk(8'(clkGate & rows[i].msk), 8'(rows[i].gt));
         chk(8'(cpuRun), 8'h00);
         axr(STATUS_OFS);
         chk(8'(d[1:0]), 8'h01);
         if (rows[i].irq) @(posedge clk) irqFlag <= 8'h01;
         else pin(8'hFE);
         waitRes(40);
         chk(8'(k), 8'(rows[i].knd));
         irqFlag <= 8'h00;
         repeat (2) @(posedge clk);
         chk(8'(clkGate & 3'h6), 8'h06);
         req(1'h0);
         axr(STATUS_OFS);
         chk(8'(d[0]), 8'h00);
         $display("row %0d done", i);
      end
      // Flag already raised before halt, and a pin without wake enable
      axw(INTCTL_OFS, 8'h00);
      irqFlag <= 8'h01;
      req(1'h1);
      pin(8'hFD);
      repeat (20) @(posedge clk);
      chk(8'(cpuRun), 8'h00);
      pin(8'hFE);
      waitRes(40);
      chk(8'(k), 8'(RES_NEXT));
      irqFlag <= 8'h00;
      $display("stale flag test done");
      // Watchdog runs a while first, but halt restarts it, so the wake still takes a full count
      axw(MODE_CTRL_OFS, 8'h00);
      axw(INTCTL_OFS, 8'h03);
      repeat (20000) @(posedge clk);
      req(1'h1);
      waitRes(70000);
      chk(8'(k), 8'(RES_WDT));
      chk(8'(pc), 8'h01);
      chk(8'(n > 60000), 8'h01);
      axw(INTCTL_OFS, 8'h00);
      chk(8'(r), 8'(RESP_OKAY));
      axr(STATUS_OFS);
      chk(8'(d[1:0]), 8'h03);
      $display("watchdog wake test done");
      // External reset while asleep
      req(1'h1);
      @(posedge clk) reset_n <= 1'h0;
      repeat (2) @(posedge clk);
      reset_n <= 1'h1;
      @(posedge clk);
      chk(8'({cpuRun, clkGate}), 8'h0F);
      axr(STATUS_OFS);
      chk(8'(d[1:0]), 8'h00);
      axr(MODE_CTRL_OFS);
      chk(d, MODE_CTRL_RST);
      axr(8'h14);
      chk(8'(r), 8'(RESP_SLVERR));
      axw(8'h14, 8'h00);
      chk(8'(r), 8'(RESP_SLVERR));
      $display("reset wake test done");
      end_sim();
   end
endmodule // test_low_power_mode_and_wakeup
